/* File: design/scsc_params.svh */
// Register indices, field positions, reset values and timing counts of the clock block.
`ifndef SCSC_PARAMS_SVH
`define SCSC_PARAMS_SVH
`define SCSC_IDX_DIV_CTL        8'h61
`define SCSC_IDX_FAST_TRIM      8'h66
`define SCSC_IDX_SLOW_TRIM      8'h67
`define SCSC_IDX_ASYNC_CTL      8'h68
`define SCSC_IDX_SRC_CTL        8'hf2
`define SCSC_SRC_CTL_RESET      8'h03
`define SCSC_DIV_CTL_RESET      4'h3
`define SCSC_TRIM_RESET         8'h80
`define SCSC_BIT_UNLOCK         7
`define SCSC_DIV_UNLOCK_CODE    8'h80
`define SCSC_DIV_SEL_MAX        4'h8
`define SCSC_SRC_UNLOCK_CYCLES  6
`define SCSC_DIV_UNLOCK_CYCLES  4
`define SCSC_WDT_HALF_COUNT     3'h7
`endif

/* File: design/scsc_pkg.sv */
// Types shared by the clock source and prescaler logic.
package scsc_pkg;

   typedef enum logic [1:0] {
      SCSC_SRC_FAST_RC   = 2'h0,
      SCSC_SRC_FAST_XTAL = 2'h1,
      SCSC_SRC_SLOW_RC   = 2'h2,
      SCSC_SRC_SLOW_XTAL = 2'h3
   } scsc_src_e;

   typedef enum logic [1:0] {
      SCSC_MUX_RUN       = 2'h0,
      SCSC_MUX_STOP_OLD  = 2'h1,
      SCSC_MUX_START_NEW = 2'h3
   } scsc_mux_e;

   typedef struct packed {
      logic       source_change_unlock;
      logic       master_source_speed;
      logic       master_source_type;
      logic       watchdog_source_select;
      logic       slow_crystal_on;
      logic       fast_crystal_on;
      logic       slow_rc_on;
      logic       fast_rc_on;
   } scsc_src_ctl_s;

   typedef struct packed {
      scsc_mux_e  state;
      scsc_src_e  cur;
      logic       out;
   } scsc_mux_s;

   typedef struct packed {
      logic       prev;
      logic [3:0] active;
      logic [7:0] cnt;
      logic       out;
      logic       tick;
   } scsc_div_s;

endpackage : scsc_pkg

/* File: design/scsc_clk_mux.sv */
// Glitch-free master source multiplexer working on synchronised oscillator levels.
module scsc_clk_mux
(
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic [3:0]        src_lvl,
   input  wire logic [3:0]        src_ok,
   input  scsc_pkg::scsc_src_e    req_sel,
   output logic                   clk_lvl,
   output scsc_pkg::scsc_src_e    cur_sel
);

   scsc_pkg::scsc_mux_s s_reg;
   scsc_pkg::scsc_mux_s s_next;

   // The old source is cut only in its low phase and the new one joins in its low phase,
   // so no pulse shorter than a half period of either source can appear.
   always_comb
   begin
      s_next = s_reg;
      case (s_reg.state)
         scsc_pkg::SCSC_MUX_RUN:
         begin
            s_next.out = src_lvl[s_reg.cur];
            if (req_sel != s_reg.cur && src_ok[req_sel])
            begin
               s_next.state = scsc_pkg::SCSC_MUX_STOP_OLD;
            end
         end
         scsc_pkg::SCSC_MUX_STOP_OLD:
         begin
            if (!src_lvl[s_reg.cur])
            begin
               s_next.out   = 1'b0;
               s_next.cur   = req_sel;
               s_next.state = scsc_pkg::SCSC_MUX_START_NEW;
            end
            else
            begin
               s_next.out = src_lvl[s_reg.cur];
            end
         end
         scsc_pkg::SCSC_MUX_START_NEW:
         begin
            s_next.out = 1'b0;
            if (!src_lvl[s_reg.cur])
            begin
               s_next.state = scsc_pkg::SCSC_MUX_RUN;
            end
         end
         default:
         begin
            s_next.state = scsc_pkg::SCSC_MUX_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '{state: scsc_pkg::SCSC_MUX_RUN, cur: scsc_pkg::SCSC_SRC_FAST_RC, out: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign clk_lvl = s_reg.out;
   assign cur_sel = s_reg.cur;

endmodule : scsc_clk_mux

/* File: design/scsc_sys_div.sv */
// System prescaler: divides the master level by a power of two, changing ratio only
// at a period boundary.
`include "scsc_params.svh"

module scsc_sys_div
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       src_lvl,
   input  wire logic [3:0] div_sel,
   output logic            clk_lvl,
   output logic            tick
);

   scsc_pkg::scsc_div_s s_reg;
   scsc_pkg::scsc_div_s s_next;
   logic                rise;
   logic [7:0]          half_m1;

   always_comb
   begin
      rise    = src_lvl & ~s_reg.prev;
      half_m1 = 8'((8'h01 << (s_reg.active - 4'h1)) - 8'h01);
      s_next      = s_reg;
      s_next.prev = src_lvl;
      if (s_reg.active == 4'h0)
      begin
         s_next.out = src_lvl;
         s_next.cnt = 8'h00;
         if (rise)
         begin
            s_next.active = div_sel;
         end
      end
      else if (rise)
      begin
         if (s_reg.cnt == half_m1)
         begin
            s_next.cnt = 8'h00;
            s_next.out = ~s_reg.out;
            // A new ratio starts only with a fresh high half, so no period is cut short.
            if (!s_reg.out)
            begin
               s_next.active = div_sel;
            end
         end
         else
         begin
            s_next.cnt = 8'(s_reg.cnt + 8'h01);
         end
      end
      s_next.tick = s_next.out & ~s_reg.out;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_reg <= '{prev: 1'b0, active: `SCSC_DIV_CTL_RESET, cnt: 8'h00, out: 1'b0, tick: 1'b0};
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign clk_lvl = s_reg.out;
   assign tick    = s_reg.tick;

endmodule : scsc_sys_div

/* File: design/scsc_top.sv */
// Clock source control, master clock selection, watchdog clock and system prescaler.
//
// Overview of operation
// - Async timer runs from external or crystal.
// - Watchdog from slow RC or fast/16.
// - Bit 4, once a source word is committed: 0 fast/16, 1 slow RC.
// - Low four bits enable the four sources.
// - Power-up: fast RC divided by eight.
// - Two-bit master select maps four sources.
// - Source writes need unlock, then timed window.
// - Valid select switches clock automatically.
// - Prescaler divides master, clocks core, peripherals.
// - Ratio change glitch-free, applied within cycles.
// - Prescaler write needs unlock within four cycles.
// - Trims load factory values, writes retune.
// - Two eight-bit trim registers, 0x66, 0x67.
// - Divider code is power of two up to 256.
// - Prescaler unlock bit clears after four cycles.
`include "scsc_params.svh"

module scsc_top
#(
   parameter int SRC_UNLOCK_CYCLES = `SCSC_SRC_UNLOCK_CYCLES,
   parameter int DIV_UNLOCK_CYCLES = `SCSC_DIV_UNLOCK_CYCLES
)
(
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [9:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   input  wire logic [3:0]  OSC_LEVEL_IN,
   input  wire logic [3:0]  OSC_STABLE_IN,
   input  wire logic        TMR_EXT_CLK_IN,
   input  wire logic        CFG_RELOAD,
   input  wire logic [7:0]  FACTORY_FAST_TRIM,
   input  wire logic [7:0]  FACTORY_SLOW_TRIM,
   output logic      [3:0]  OSC_ENABLE,
   output logic      [7:0]  FAST_RC_TRIM,
   output logic      [7:0]  SLOW_RC_TRIM,
   output logic             SYS_CLK,
   output logic             SYS_CLK_TICK,
   output logic      [1:0]  ACTIVE_SOURCE,
   output logic             WATCHDOG_CLOCK,
   output logic             WDT_SRC_SLOW,
   output logic             ASYNC_TMR_CLK
);

   if (SRC_UNLOCK_CYCLES < 1 || SRC_UNLOCK_CYCLES > 15)
   begin : g_bad_src_win
      $error("SRC_UNLOCK_CYCLES must lie in 1..15");
   end
   if (DIV_UNLOCK_CYCLES < 1 || DIV_UNLOCK_CYCLES > 15)
   begin : g_bad_div_win
      $error("DIV_UNLOCK_CYCLES must lie in 1..15");
   end

   localparam logic [3:0] SRC_WIN = 4'(SRC_UNLOCK_CYCLES);
   localparam logic [3:0] DIV_WIN = 4'(DIV_UNLOCK_CYCLES);

   typedef struct packed {
      logic [3:0]              osc_sync1;
      logic [3:0]              osc_sync2;
      logic [3:0]              ok_sync1;
      logic [3:0]              ok_sync2;
      logic                    ext_sync1;
      logic                    ext_sync2;
      scsc_pkg::scsc_src_ctl_s src_ctl;
      logic [3:0]              src_win;
      logic [3:0]              div_sel;
      logic [3:0]              div_win;
      logic [7:0]              fast_trim;
      logic [7:0]              slow_trim;
      logic                    async_ext;
      logic                    loaded;
      logic                    wdt_chosen;
      logic                    fast_prev;
      logic [2:0]              wdt_cnt;
      logic                    wdt_div;
      logic                    watchdog_clock;
      logic                    wdt_slow;
      logic                    tmr_clk;
      logic                    ack;
      logic [31:0]             dat;
   } scsc_top_s;

   scsc_top_s           s_reg;
   scsc_top_s           s_next;
   logic                wr;
   logic [7:0]          idx;
   logic [7:0]          wd;
   logic [7:0]          rd;
   logic                fast_rise;
   logic                mux_lvl;
   scsc_pkg::scsc_src_e mux_cur;
   scsc_pkg::scsc_src_e req_sel;
   logic [3:0]          lvl_by_code;
   logic [3:0]          ok_by_code;

   localparam scsc_top_s RESET_STATE = '{
      osc_sync1:  4'h0,
      osc_sync2:  4'h0,
      ok_sync1:   4'h0,
      ok_sync2:   4'h0,
      ext_sync1:  1'b0,
      ext_sync2:  1'b0,
      src_ctl:    `SCSC_SRC_CTL_RESET,
      src_win:    4'h0,
      div_sel:    `SCSC_DIV_CTL_RESET,
      div_win:    4'h0,
      fast_trim:  `SCSC_TRIM_RESET,
      slow_trim:  `SCSC_TRIM_RESET,
      async_ext:  1'b0,
      loaded:     1'b0,
      wdt_chosen: 1'b0,
      fast_prev:  1'b0,
      wdt_cnt:    3'h0,
      wdt_div:    1'b0,
      watchdog_clock:    1'b0,
      wdt_slow:   1'b1,
      tmr_clk:    1'b0,
      ack:        1'b0,
      dat:        32'h0000_0000
   };

   always_comb
   begin
      s_next = s_reg;

      // Oscillator and pin levels are foreign to CLK and pass two flops first.
      s_next.osc_sync1 = OSC_LEVEL_IN;
      s_next.osc_sync2 = s_reg.osc_sync1;
      s_next.ok_sync1  = OSC_STABLE_IN;
      s_next.ok_sync2  = s_reg.ok_sync1;
      s_next.ext_sync1 = TMR_EXT_CLK_IN;
      s_next.ext_sync2 = s_reg.ext_sync1;

      idx = WB_ADR_I[9:2];
      wd  = WB_DAT_I[7:0];
      // The write lands on the edge at which the master sees ack.
      wr  = WB_CYC_I & WB_STB_I & WB_WE_I & s_reg.ack & WB_SEL_I[0];

      // Unlock windows count down on every clock and close by themselves.
      if (s_reg.src_win != 4'h0)
      begin
         s_next.src_win = 4'(s_reg.src_win - 4'h1);
      end
      if (s_reg.div_win != 4'h0)
      begin
         s_next.div_win = 4'(s_reg.div_win - 4'h1);
      end

      if (wr && idx == `SCSC_IDX_SRC_CTL)
      begin
         if (wd[`SCSC_BIT_UNLOCK])
         begin
            s_next.src_win = SRC_WIN;
         end
         else if (s_reg.src_win != 4'h0)
         begin
            s_next.src_ctl    = wd;
            s_next.wdt_chosen = 1'b1;
            s_next.src_win    = 4'h0;
         end
      end

      if (wr && idx == `SCSC_IDX_DIV_CTL)
      begin
         if (wd == `SCSC_DIV_UNLOCK_CODE)
         begin
            s_next.div_win = DIV_WIN;
         end
         else if (!wd[`SCSC_BIT_UNLOCK] && s_reg.div_win != 4'h0)
         begin
            // Reserved codes leave the current ratio in place.
            if (wd[3:0] <= `SCSC_DIV_SEL_MAX)
            begin
               s_next.div_sel = wd[3:0];
            end
            s_next.div_win = 4'h0;
         end
      end

      if (wr && idx == `SCSC_IDX_FAST_TRIM)
      begin
         s_next.fast_trim = wd;
      end
      if (wr && idx == `SCSC_IDX_SLOW_TRIM)
      begin
         s_next.slow_trim = wd;
      end
      if (wr && idx == `SCSC_IDX_ASYNC_CTL)
      begin
         s_next.async_ext = wd[0];
      end

      // Factory values arrive the first clock after reset and again on every reload.
      if (!s_reg.loaded || CFG_RELOAD)
      begin
         s_next.fast_trim = FACTORY_FAST_TRIM;
         s_next.slow_trim = FACTORY_SLOW_TRIM;
         s_next.loaded    = 1'b1;
      end

      s_next.src_ctl.source_change_unlock = (s_next.src_win != 4'h0);

      // Fast RC divided by sixteen: toggle on every eighth rising edge.
      fast_rise         = s_reg.osc_sync2[0] & ~s_reg.fast_prev;
      s_next.fast_prev  = s_reg.osc_sync2[0];
      if (fast_rise)
      begin
         s_next.wdt_cnt = 3'(s_reg.wdt_cnt + 3'h1);
         if (s_reg.wdt_cnt == `SCSC_WDT_HALF_COUNT)
         begin
            s_next.wdt_div = ~s_reg.wdt_div;
         end
      end

      // Until software commits a source word, the watchdog stays on the slow RC.
      s_next.wdt_slow = s_reg.wdt_chosen ? s_reg.src_ctl.watchdog_source_select : 1'b1;
      s_next.watchdog_clock  = s_reg.wdt_slow ? s_reg.osc_sync2[1] : s_reg.wdt_div;

      s_next.tmr_clk = s_reg.async_ext ? s_reg.ext_sync2 : s_reg.osc_sync2[3];

      case (idx)
         `SCSC_IDX_SRC_CTL:   rd = s_reg.src_ctl;
         `SCSC_IDX_DIV_CTL:   rd = {s_reg.div_win != 4'h0, 3'h0, s_reg.div_sel};
         `SCSC_IDX_FAST_TRIM: rd = s_reg.fast_trim;
         `SCSC_IDX_SLOW_TRIM: rd = s_reg.slow_trim;
         `SCSC_IDX_ASYNC_CTL: rd = {7'h00, s_reg.async_ext};
         default:             rd = 8'h00;
      endcase

      s_next.ack = WB_CYC_I & WB_STB_I & ~s_reg.ack;
      if (s_next.ack)
      begin
         s_next.dat = {24'h00_0000, rd};
      end
   end

   always_ff @(posedge CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         s_reg <= RESET_STATE;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // A source counts as ready only while it is both switched on and reported stable.
   assign req_sel = scsc_pkg::scsc_src_e'({s_reg.src_ctl.master_source_speed,
                                           s_reg.src_ctl.master_source_type});

   // Pins and enables run fast RC, slow RC, fast crystal, slow crystal, but select
   // codes 01 and 10 name the fast crystal and the slow RC, so the middle two swap.
   assign lvl_by_code = {s_reg.osc_sync2[3], s_reg.osc_sync2[1], s_reg.osc_sync2[2],
                         s_reg.osc_sync2[0]};
   assign ok_by_code  = {s_reg.ok_sync2[3] & s_reg.src_ctl.slow_crystal_on,
                         s_reg.ok_sync2[1] & s_reg.src_ctl.slow_rc_on,
                         s_reg.ok_sync2[2] & s_reg.src_ctl.fast_crystal_on,
                         s_reg.ok_sync2[0] & s_reg.src_ctl.fast_rc_on};

   scsc_clk_mux u_mux
   (
      .clk     (CLK),
      .nrst    (NRST),
      .src_lvl (lvl_by_code),
      .src_ok  (ok_by_code),
      .req_sel (req_sel),
      .clk_lvl (mux_lvl),
      .cur_sel (mux_cur)
   );

   scsc_sys_div u_div
   (
      .clk     (CLK),
      .nrst    (NRST),
      .src_lvl (mux_lvl),
      .div_sel (s_reg.div_sel),
      .clk_lvl (SYS_CLK),
      .tick    (SYS_CLK_TICK)
   );

   assign WB_DAT_O      = s_reg.dat;
   assign WB_ACK_O      = s_reg.ack;
   assign OSC_ENABLE    = s_reg.src_ctl[3:0];
   assign FAST_RC_TRIM  = s_reg.fast_trim;
   assign SLOW_RC_TRIM  = s_reg.slow_trim;
   assign ACTIVE_SOURCE = mux_cur;
   assign WATCHDOG_CLOCK       = s_reg.watchdog_clock;
   assign WDT_SRC_SLOW  = s_reg.wdt_slow;
   assign ASYNC_TMR_CLK = s_reg.tmr_clk;

endmodule : scsc_top

/* File: verif/scsc_top_checker.sv */
// Port-level concurrent checks for the clock source control block.
module scsc_top_checker
(
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        CFG_RELOAD,
   input wire logic [7:0]  FACTORY_FAST_TRIM,
   input wire logic [7:0]  FACTORY_SLOW_TRIM,
   input wire logic [3:0]  OSC_ENABLE,
   input wire logic [7:0]  FAST_RC_TRIM,
   input wire logic [7:0]  SLOW_RC_TRIM,
   input wire logic        SYS_CLK_TICK,
   input wire logic [1:0]  ACTIVE_SOURCE,
   input wire logic        WDT_SRC_SLOW
);
   default clocking dflt_cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   logic wr_ack;
   logic act_en;

   assign wr_ack = WB_ACK_O && WB_WE_I;
   // Select codes 01 and 10 sit on enable bits 2 and 1, hence the swapped index.
   assign act_en = OSC_ENABLE[{ACTIVE_SOURCE[0], ACTIVE_SOURCE[1]}];

   chk_ack_answers: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("bus request not answered in one cycle");
   chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   chk_read_upper: assert property (WB_ACK_O |-> (WB_DAT_O[31:8] == 24'h0))
      else $error("upper read data not zero");
   chk_enable_cause: assert property ($changed(OSC_ENABLE) |-> ($past(wr_ack) || $past(wr_ack, 2)))
      else $error("source enables changed without a write");
   chk_wdt_cause: assert property ($changed(WDT_SRC_SLOW) |-> ($past(wr_ack) || $past(wr_ack, 2)))
      else $error("watchdog source changed without a write");
   chk_trim_reload: assert property (CFG_RELOAD |=>
      (FAST_RC_TRIM == $past(FACTORY_FAST_TRIM)) && (SLOW_RC_TRIM == $past(FACTORY_SLOW_TRIM)))
      else $error("trim reload did not restore factory values");
   chk_tick_single: assert property (SYS_CLK_TICK |=> !SYS_CLK_TICK)
      else $error("system tick longer than one cycle");
   chk_switch_enabled: assert property ($changed(ACTIVE_SOURCE) |-> act_en)
      else $error("master moved to a disabled source");

   cover property ($changed(ACTIVE_SOURCE));
   cover property (CFG_RELOAD);
   cover property (wr_ack ##2 $changed(OSC_ENABLE));
   cover property (SYS_CLK_TICK ##4 SYS_CLK_TICK);
endmodule : scsc_top_checker

bind scsc_top scsc_top_checker chk_u (.CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .CFG_RELOAD(CFG_RELOAD), .FACTORY_FAST_TRIM(FACTORY_FAST_TRIM),
   .FACTORY_SLOW_TRIM(FACTORY_SLOW_TRIM), .OSC_ENABLE(OSC_ENABLE),
   .FAST_RC_TRIM(FAST_RC_TRIM), .SLOW_RC_TRIM(SLOW_RC_TRIM), .SYS_CLK_TICK(SYS_CLK_TICK),
   .ACTIVE_SOURCE(ACTIVE_SOURCE), .WDT_SRC_SLOW(WDT_SRC_SLOW));

/* File: verif/test_system_clock_source_control.sv */
// Self-checking bench for the clock source control block.
`include "scsc_params.svh"

module test_system_clock_source_control;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] F_FAST = 8'h5a;
   localparam logic [7:0] F_SLOW = 8'ha5;

   logic        clk, nrst, cyc, stb, we, cfg_reload, ack, tick, sclk, wdt, wdt_slow, aclk;
   logic [9:0]  adr;
   logic [31:0] dat, rdat;
   logic [3:0]  osc_stable, en;
   logic [7:0]  ph = 8'h00;
   logic [7:0]  ftrim, strim;
   logic [1:0]  act;
   int          n_errors = 0;
   int          samples_checked = 0;
   int          n;

   // The fast crystal stays silent until it is enabled, as a real crystal would.
   always @(posedge clk) ph <= ph + 8'h01;

   scsc_top dut_u (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .OSC_LEVEL_IN({ph[3], ph[2] & en[2], ph[4], ph[1]}), .OSC_STABLE_IN(osc_stable),
      .TMR_EXT_CLK_IN(ph[5]), .CFG_RELOAD(cfg_reload), .FACTORY_FAST_TRIM(F_FAST),
      .FACTORY_SLOW_TRIM(F_SLOW), .OSC_ENABLE(en), .FAST_RC_TRIM(ftrim),
      .SLOW_RC_TRIM(strim), .SYS_CLK(sclk), .SYS_CLK_TICK(tick), .ACTIVE_SOURCE(act),
      .WATCHDOG_CLOCK(wdt), .WDT_SRC_SLOW(wdt_slow), .ASYNC_TMR_CLK(aclk));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= {idx, 2'b00};
      dat <= {24'h0, d};
      do
      begin
         @(negedge clk);
      end
      while (ack !== 1'b1);
      @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, idx, d, q);
   endtask : wr

   task automatic rd(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      xfer(1'b0, idx, 8'h00, q);
      check(what, {24'h0, exp}, q);
   endtask : rd

   // Skips two ticks so that a ratio change has landed before the interval is timed.
   task automatic spacing(input logic [31:0] exp);
      logic [31:0] p;
      int          t;
      int          k;
      p = 0;
      t = 0;
      k = 0;
      while (t < 3 && k < 8000)
      begin
         @(negedge clk);
         k++;
         p++;
         if (tick === 1'b1)
         begin
            t++;
            if (t < 3)
               p = 0;
         end
      end
      check("tick spacing", exp, p);
   endtask : spacing

   // Counts rising edges of a level output over 256 cycles: 0 timer, 1 watchdog, 2 system.
   task automatic rate(input string what, input int sel, input logic [31:0] exp);
      logic [31:0] r;
      logic        v;
      logic        pv;
      r  = 0;
      pv = 1'b0;
      for (int i = 0; i <= 256; i++)
      begin
         @(negedge clk);
         v = (sel == 0) ? aclk : (sel == 1) ? wdt : sclk;
         if (i > 0 && v === 1'b1 && pv === 1'b0)
            r++;
         pv = v;
      end
      check(what, exp, r);
   endtask : rate

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (40000) @(posedge clk);
      n_errors++;
      tally_and_finish();
   end

   initial
   begin
      nrst = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 10'h000;
      dat = 32'h0;
      cfg_reload = 1'b0;
      osc_stable = 4'b0011;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      rd("source ctl", `SCSC_IDX_SRC_CTL, 8'h03);
      rd("divider", `SCSC_IDX_DIV_CTL, 8'h03);
      rd("unmapped", 8'h10, 8'h00);
      check("enables", 32'h3, {28'h0, en});
      check("active", 32'h0, {30'h0, act});
      check("wdt slow", 32'h1, {31'h0, wdt_slow});
      check("fast trim", {24'h0, F_FAST}, {24'h0, ftrim});
      check("slow trim", {24'h0, F_SLOW}, {24'h0, strim});
      spacing(32'd32);
      rate("sys clk", 2, 32'd8);
      wr(`SCSC_IDX_SRC_CTL, 8'h07);
      wr(`SCSC_IDX_SRC_CTL, 8'h80);
      rd("window open", `SCSC_IDX_SRC_CTL, 8'h83);
      repeat (10) @(posedge clk);
      rd("window shut", `SCSC_IDX_SRC_CTL, 8'h03);
      wr(`SCSC_IDX_SRC_CTL, 8'h07);
      rd("late write", `SCSC_IDX_SRC_CTL, 8'h03);
      wr(`SCSC_IDX_SRC_CTL, 8'h80);
      wr(`SCSC_IDX_SRC_CTL, 8'h07);
      repeat (3) @(negedge clk);
      check("enables", 32'h7, {28'h0, en});
      check("wdt slow", 32'h0, {31'h0, wdt_slow});
      rate("wdt fast/16", 1, 32'd4);
      @(posedge clk);
      osc_stable <= 4'b0111;
      wr(`SCSC_IDX_SRC_CTL, 8'h80);
      wr(`SCSC_IDX_SRC_CTL, 8'h37);
      n = 0;
      while (act !== 2'h1 && n < 500)
      begin
         @(negedge clk);
         n++;
      end
      check("active", 32'h1, {30'h0, act});
      check("wdt slow", 32'h1, {31'h0, wdt_slow});
      rate("wdt slow rc", 1, 32'd8);
      wr(`SCSC_IDX_SRC_CTL, 8'h80);
      wr(`SCSC_IDX_SRC_CTL, 8'h36);
      @(negedge clk);
      check("rc stopped", 32'h6, {28'h0, en});
      check("still crystal", 32'h1, {30'h0, act});
      for (int c = 0; c < 9; c++)
      begin
         wr(`SCSC_IDX_DIV_CTL, `SCSC_DIV_UNLOCK_CODE);
         wr(`SCSC_IDX_DIV_CTL, 8'(c));
         spacing(32'd8 << c);
      end
      rd("divider", `SCSC_IDX_DIV_CTL, 8'h08);
      wr(`SCSC_IDX_DIV_CTL, 8'h02);
      rd("divider locked", `SCSC_IDX_DIV_CTL, 8'h08);
      wr(`SCSC_IDX_DIV_CTL, `SCSC_DIV_UNLOCK_CODE);
      wr(`SCSC_IDX_DIV_CTL, 8'h09);
      rd("divider reserved", `SCSC_IDX_DIV_CTL, 8'h08);
      wr(`SCSC_IDX_DIV_CTL, `SCSC_DIV_UNLOCK_CODE);
      rd("divider window", `SCSC_IDX_DIV_CTL, 8'h88);
      rd("divider shut", `SCSC_IDX_DIV_CTL, 8'h08);
      wr(`SCSC_IDX_FAST_TRIM, 8'h3c);
      wr(`SCSC_IDX_SLOW_TRIM, 8'hc3);
      rd("fast trim", `SCSC_IDX_FAST_TRIM, 8'h3c);
      rd("slow trim", `SCSC_IDX_SLOW_TRIM, 8'hc3);
      check("fast trim out", 32'h3c, {24'h0, ftrim});
      rate("timer clk", 0, 32'd16);
      wr(`SCSC_IDX_ASYNC_CTL, 8'h01);
      rd("timer select", `SCSC_IDX_ASYNC_CTL, 8'h01);
      rate("timer ext", 0, 32'd4);
      @(posedge clk);
      cfg_reload <= 1'b1;
      @(posedge clk);
      cfg_reload <= 1'b0;
      repeat (2) @(negedge clk);
      check("fast trim", {24'h0, F_FAST}, {24'h0, ftrim});
      check("slow trim", {24'h0, F_SLOW}, {24'h0, strim});
      tally_and_finish();
   end
endmodule : test_system_clock_source_control
